// ---- sfp_flash_end.sv ----
// Flash end of the link: selection, command capture, status guard, answers
`timescale 1ns/1ps
module sfp_flash_end (
    sfp_link_if.dev         link,
    input  wire logic       rst,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] status_word,
    output logic            func_select,
    output logic      [7:0] rx_byte,
    output logic            rx_toggle,
    output logic            dev_active
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_CMD  = 4'b0001,
        PH_ARG  = 4'b0010,
        PH_OUT  = 4'b0100,
        PH_DONE = 4'b1000
    } sfp_phase_e;

    // Per-frame state, wiped whenever the frame ends
    typedef struct packed {
        sfp_phase_e phase;
        logic [7:0] cmd;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic       held;
        logic       active;
    } sfp_frame_s;

    // State that outlives a frame
    typedef struct packed {
        logic [7:0] status;
        logic       fsel;
        logic [7:0] rx;
        logic       rx_tog;
    } sfp_keep_s;

    sfp_frame_s f_q;
    sfp_frame_s f_d;
    sfp_keep_s  k_q;
    sfp_keep_s  k_d;
    logic       armed_q;
    logic       quad_on;
    logic       pause;
    logic       restart;
    logic       frame_clr;
    logic       locked;
    logic [7:0] arg;
    logic [7:0] out_byte;
    logic       out_en;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------

    // Where a frame goes once its instruction byte is complete
    function automatic sfp_phase_e next_phase(input logic [7:0] op, input logic quad);
        case (op)
            sfp_pkg::OP_WRITE_STATUS,
            sfp_pkg::OP_WRITE_FUNC,
            sfp_pkg::OP_WRITE_DATA:  next_phase = PH_ARG;
            sfp_pkg::OP_READ_STATUS,
            sfp_pkg::OP_READ_FUNC,
            sfp_pkg::OP_READ_DATA,
            sfp_pkg::OP_READ_DUAL:   next_phase = PH_OUT;
            sfp_pkg::OP_READ_QUAD:   next_phase = quad ? PH_OUT : PH_DONE;
            default:                 next_phase = PH_DONE;
        endcase
    endfunction : next_phase

    // Lanes used by the answer of an instruction
    function automatic logic [1:0] answer_lanes(input logic [7:0] op);
        case (op)
            sfp_pkg::OP_READ_DUAL: answer_lanes = sfp_pkg::LANE2;
            sfp_pkg::OP_READ_QUAD: answer_lanes = sfp_pkg::LANE4;
            default:               answer_lanes = sfp_pkg::LANE1;
        endcase
    endfunction : answer_lanes

    // ------------------------------------------------------------
    // Pin functions
    // ------------------------------------------------------------

    // Line 3 is pause or restart only while quad lines are off
    assign quad_on = k_q.status[sfp_pkg::ST_QUAD];
    assign pause   = ~quad_on & ~k_q.fsel & ~link.line[3] & ~link.cs_n;
    assign restart = ~quad_on & k_q.fsel & ~link.line[3];

    // A frame ends on deselect, restart or reset; the sequence restarts
    assign frame_clr = rst | link.cs_n | restart;

    // Protect pin only guards when lock is set and quad is off
    assign locked = k_q.status[sfp_pkg::ST_LOCK] & ~quad_on & ~link.line[2];

    // Argument byte including the bit arriving on this edge
    assign arg = {f_q.sh[6:0], link.line[0]};

    // ------------------------------------------------------------
    // Power-up arming
    // ------------------------------------------------------------

    // Armed only by a select rise after reset, so the next fall is seen
    always_ff @(posedge link.cs_n or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Rising-edge capture
    // ------------------------------------------------------------

    // Pause freezes every field but held and active, so a resumed frame picks up exactly
    always_comb begin
        f_d = f_q;
        k_d = k_q;
        f_d.active = 1'b1;
        f_d.held = pause;
        if (!pause && armed_q) begin
            case (f_q.phase)
                PH_CMD: begin
                    f_d.cmd = {f_q.cmd[6:0], link.line[0]};
                    f_d.cnt = f_q.cnt + 3'h1;
                    if (f_q.cnt == sfp_pkg::LAST_BIT) begin
                        f_d.phase = next_phase(f_d.cmd, quad_on);
                    end
                end
                PH_ARG: begin
                    f_d.sh = arg;
                    f_d.cnt = f_q.cnt + 3'h1;
                    if (f_q.cnt == sfp_pkg::LAST_BIT) begin
                        f_d.phase = PH_DONE;
                        case (f_q.cmd)
                            sfp_pkg::OP_WRITE_STATUS: begin
                                if (!locked) begin
                                    k_d.status = arg & sfp_pkg::ST_WR_MASK;
                                end
                            end
                            sfp_pkg::OP_WRITE_FUNC: begin
                                k_d.fsel = arg[sfp_pkg::FN_SEL];
                            end
                            sfp_pkg::OP_WRITE_DATA: begin
                                k_d.rx = arg;
                                k_d.rx_tog = ~k_q.rx_tog;
                            end
                            default: begin
                                k_d.rx_tog = k_q.rx_tog;
                            end
                        endcase
                    end
                end
                PH_OUT, PH_DONE: begin
                    f_d.cnt = f_q.cnt;
                end
                default: begin
                    f_d.phase = PH_DONE;
                end
            endcase
        end
    end

    // Frame state is cleared straight from the select pin
    always_ff @(posedge link.sck or posedge frame_clr) begin
        if (frame_clr) begin
            f_q <= '{phase: PH_CMD, cmd: 8'h00, sh: 8'h00, cnt: 3'h0,
                     held: 1'b0, active: 1'b0};
        end else begin
            f_q <= f_d;
        end
    end

    // Status and received data survive deselect and restart
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            k_q <= '{status: sfp_pkg::STATUS_RST, fsel: sfp_pkg::FN_SEL_RST,
                     rx: 8'h00, rx_tog: 1'b0};
        end else begin
            k_q <= k_d;
        end
    end

    // ------------------------------------------------------------
    // Answer path
    // ------------------------------------------------------------

    // Byte offered for the answer phase
    always_comb begin
        case (f_q.cmd)
            sfp_pkg::OP_READ_STATUS: out_byte = k_q.status;
            sfp_pkg::OP_READ_FUNC:   out_byte = {k_q.fsel, 7'h00};
            default:                 out_byte = tx_byte;
        endcase
    end

    // Lines drive only in the answer phase and not while paused;
    // the float on pause lands at the next fall, half a clock later
    assign out_en = (f_q.phase == PH_OUT) & ~f_q.held;

    sfp_shift_out u_out (
        .sck     (link.sck),
        .clr     (frame_clr),
        .en      (out_en),
        .byte_in (out_byte),
        .lanes   (answer_lanes(f_q.cmd)),
        .line_o  (link.dev_o),
        .line_oe (link.dev_oe)
    );

    // ------------------------------------------------------------
    // User-side outputs
    // ------------------------------------------------------------
    assign status_word = k_q.status;
    assign func_select = k_q.fsel;
    assign rx_byte     = k_q.rx;
    assign rx_toggle   = k_q.rx_tog;
    assign dev_active  = f_q.active;

endmodule : sfp_flash_end

// ---- sfp_pkg.sv ----
// Constants and shared helpers of the serial flash pin link
package sfp_pkg;
// Contract
// - Deselected device floats every output pin
// - Standby while deselected, active once selected; dev_active only rises at the first clock rise after the select fall
// - Instructions need a select fall after reset
// - Bits seen while deselected are ignored
// - Single mode: input line sampled on rise
// - Single mode: output line changes on fall
// - Dual/quad: lines bidirectional, rise in, fall out
// - Quad uses protect and pause pins as data
// - Lock set, protect pin low: status write refused
// - Lock clear: status writes always allowed
// - Quad enable turns off the protect function
// - Quad enable turns off pause and restart
// - Select bit picks pause or restart function
// - Pause suspends the sequence without losing it
// - Pause while selected floats the output line
// - Releasing pause resumes where it stopped
// - Restart low holds device reset, outputs floating
// - Host avoids restart during internal writes

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_DATA   = 8'h02;
    localparam logic [7:0] OP_READ_DATA    = 8'h03;
    localparam logic [7:0] OP_READ_STATUS  = 8'h05;
    localparam logic [7:0] OP_READ_DUAL    = 8'h3b;
    localparam logic [7:0] OP_WRITE_FUNC   = 8'h42;
    localparam logic [7:0] OP_READ_FUNC    = 8'h48;
    localparam logic [7:0] OP_READ_QUAD    = 8'h6b;

    // ------------------------------------------------------------
    // Status and function register layout
    // ------------------------------------------------------------
    localparam int         ST_LOCK      = 7;   // status_write_lock
    localparam int         ST_QUAD      = 6;   // quad_lines_enable
    localparam logic [7:0] ST_WR_MASK   = 8'hfc;
    localparam logic [7:0] STATUS_RST   = 8'h00;
    localparam int         FN_SEL       = 7;   // line3_function_select
    localparam logic       FN_SEL_RST   = 1'b0;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    // ------------------------------------------------------------
    // Lane widths and transfer kinds
    // ------------------------------------------------------------
    localparam logic [1:0] LANE1     = 2'h0;
    localparam logic [1:0] LANE2     = 2'h1;
    localparam logic [1:0] LANE4     = 2'h2;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_WR   = 2'h1;
    localparam logic [1:0] KIND_RD   = 2'h2;

    // ------------------------------------------------------------
    // Host register map and link timing
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CMD     = 8'h00;
    localparam logic [7:0] ADR_STAT    = 8'h04;
    localparam logic [7:0] ADR_PIN     = 8'h08;
    localparam int         CMD_ARG_LO  = 8;
    localparam int         CMD_KIND_LO = 16;
    localparam int         CMD_LANE_LO = 18;
    localparam int         STAT_RX_LO  = 8;
    localparam logic [1:0] PIN_RST     = 2'h3;
    localparam logic [2:0] SCK_HALF    = 3'h4;   // clk_sys cycles per half period

    // Clock edges needed to move one byte over the given lanes
    function automatic logic [3:0] edges_per_byte(input logic [1:0] lanes);
        case (lanes)
            LANE2:   edges_per_byte = 4'h4;
            LANE4:   edges_per_byte = 4'h2;
            default: edges_per_byte = 4'h8;
        endcase
    endfunction : edges_per_byte

endpackage : sfp_pkg

// ---- sfp_link_if.sv ----
// Pin-level link between the host end and the flash end
`timescale 1ns/1ps
interface sfp_link_if;
    logic       sck;
    logic       cs_n;
    logic [3:0] host_o;
    logic [3:0] host_oe;
    logic [3:0] dev_o;
    logic [3:0] dev_oe;
    logic [3:0] line;

    // Wire level: device first, then host, else pull-up
    assign line = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

    modport host (output sck, output cs_n, output host_o, output host_oe, input line);
    modport dev  (input sck, input cs_n, input line, output dev_o, output dev_oe);
endinterface : sfp_link_if

// ---- sfp_shift_out.sv ----
// Falling-edge output stage of the flash end
`timescale 1ns/1ps
module sfp_shift_out (
    input  wire logic       sck,
    input  wire logic       clr,
    input  wire logic       en,
    input  wire logic [7:0] byte_in,
    input  wire logic [1:0] lanes,
    output logic      [3:0] line_o,
    output logic      [3:0] line_oe
);
    typedef struct packed {
        logic [7:0] sh;
        logic       loaded;
        logic [3:0] o;
        logic [3:0] oe;
    } sfp_out_s;

    sfp_out_s q;
    sfp_out_s d;
    logic [7:0] cur;

    // Load on the first fall, then rotate; pausing keeps the byte
    always_comb begin
        d = q;
        d.oe = 4'h0;
        cur = q.sh;
        if (en) begin
            if (!q.loaded) begin
                cur = byte_in;
            end else begin
                case (lanes)
                    sfp_pkg::LANE2: cur = {q.sh[5:0], q.sh[7:6]};
                    sfp_pkg::LANE4: cur = {q.sh[3:0], q.sh[7:4]};
                    default:        cur = {q.sh[6:0], q.sh[7]};
                endcase
            end
            d.sh = cur;
            d.loaded = 1'b1;
            case (lanes)
                sfp_pkg::LANE2: begin
                    d.o = {2'b00, cur[7], cur[6]};
                    d.oe = 4'h3;
                end
                sfp_pkg::LANE4: begin
                    d.o = cur[7:4];
                    d.oe = 4'hf;
                end
                default: begin
                    d.o = {2'b00, cur[7], 1'b0};
                    d.oe = 4'h2;
                end
            endcase
        end
    end

    // Outputs change only on the falling link clock edge or on the asynchronous clear
    always_ff @(negedge sck or posedge clr) begin
        if (clr) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign line_o  = q.o;
    assign line_oe = q.oe;
endmodule : sfp_shift_out

// ---- sfp_host_end.sv ----
// Host end of the link: Wishbone registers and frame sequencer
`timescale 1ns/1ps
module sfp_host_end (
    sfp_link_if.host         link,
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o
);
    typedef enum logic [3:0] {
        H_WAKE = 4'b0001,
        H_IDLE = 4'b0010,
        H_RUN  = 4'b0100,
        H_END  = 4'b1000
    } sfp_host_e;

    typedef struct packed {
        sfp_host_e  st;
        logic [2:0] div;
        logic       sck;
        logic       cs_n;
        logic [3:0] o;
        logic [3:0] oe;
        logic [19:0] cmd;
        logic [1:0] pin;
        logic       part;
        logic       run;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rx;
        logic       ack;
        logic [31:0] dat;
        logic [3:0] s1;
        logic [3:0] s2;
    } sfp_host_s;

    sfp_host_s  q;
    sfp_host_s  d;
    logic       tick;
    logic       paused;
    logic       wr;
    logic [1:0] kind;
    logic [1:0] lanes;

    assign tick   = (q.div == 3'h0);
    assign paused = ~q.pin[1];          // Line 3 low: hold the sequence too
    assign kind   = q.cmd[sfp_pkg::CMD_KIND_LO +: 2];
    assign lanes  = q.cmd[sfp_pkg::CMD_LANE_LO +: 2];
    assign wr     = cyc_i & stb_i & we_i & ~q.ack;

    // Divider, frame sequencer and register slave in one step
    always_comb begin
        d = q;
        d.s1 = link.line;
        d.s2 = q.s1;
        d.div = tick ? sfp_pkg::SCK_HALF - 3'h1 : q.div - 3'h1;
        d.ack = cyc_i & stb_i & ~q.ack;
        case (adr_i)
            sfp_pkg::ADR_CMD:  d.dat = {12'h000, q.cmd};
            sfp_pkg::ADR_STAT: d.dat = {16'h0000, q.rx, 7'h00, q.st != H_IDLE};
            sfp_pkg::ADR_PIN:  d.dat = {30'h0000_0000, q.pin};
            default:           d.dat = 32'h0000_0000;
        endcase
        if (wr && adr_i == sfp_pkg::ADR_PIN && sel_i[0]) begin
            d.pin = dat_i[1:0];
        end
        case (q.st)
            H_WAKE: begin
                if (tick) begin
                    d.cs_n = ~q.cs_n;
                    if (!q.cs_n) begin
                        d.st = H_IDLE;
                    end
                end
            end
            H_IDLE: begin
                if (wr && adr_i == sfp_pkg::ADR_CMD && sel_i[2:0] == 3'h7) begin
                    d.cmd = dat_i[19:0];
                    d.sh = dat_i[7:0];
                    d.o[0] = dat_i[7];
                    d.oe[0] = 1'b1;
                    d.cs_n = 1'b0;
                    d.sck = 1'b0;
                    d.part = 1'b0;
                    d.cnt = sfp_pkg::edges_per_byte(sfp_pkg::LANE1);
                    d.div = sfp_pkg::SCK_HALF - 3'h1;
                    d.st = H_RUN;
                end
            end
            H_RUN: begin
                if (tick) begin
                    d.sck = ~q.sck;
                    if (!q.sck) begin
                        d.run = !paused;    // Fall shifts only after a taken rise
                    end
                    if (!q.sck && !paused) begin
                        // Rise: device samples; host takes answer bits
                        d.cnt = q.cnt - 4'h1;
                        if (q.part && kind == sfp_pkg::KIND_RD) begin
                            case (lanes)
                                sfp_pkg::LANE2: d.rx = {q.rx[5:0], q.s2[1:0]};
                                sfp_pkg::LANE4: d.rx = {q.rx[3:0], q.s2};
                                default:        d.rx = {q.rx[6:0], q.s2[1]};
                            endcase
                        end
                    end else if (q.sck && q.run) begin
                        // Fall: host presents its next bit
                        d.sh = {q.sh[6:0], 1'b0};
                        d.o[0] = q.sh[6];
                        if (q.cnt == 4'h0) begin
                            if (!q.part && kind == sfp_pkg::KIND_WR) begin
                                d.part = 1'b1;
                                d.sh = q.cmd[sfp_pkg::CMD_ARG_LO +: 8];
                                d.o[0] = q.cmd[sfp_pkg::CMD_ARG_LO + 7];
                                d.cnt = sfp_pkg::edges_per_byte(sfp_pkg::LANE1);
                            end else if (!q.part && kind == sfp_pkg::KIND_RD) begin
                                d.part = 1'b1;
                                d.cnt = sfp_pkg::edges_per_byte(lanes);
                                d.oe[0] = (lanes == sfp_pkg::LANE1);
                            end else begin
                                d.st = H_END;
                            end
                        end
                    end
                end
            end
            H_END: begin
                if (tick) begin
                    d.cs_n = 1'b1;
                    d.oe[0] = 1'b0;
                    d.part = 1'b0;
                    d.st = H_IDLE;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
        // Protect and line 3 levels, released for a quad answer; the level
        // lags PIN by a cycle so the device sees the pause the host acts on
        d.o[3:2] = q.pin;
        d.oe[3:2] = (d.part && kind == sfp_pkg::KIND_RD && lanes == sfp_pkg::LANE4)
                    ? 2'b00 : 2'b11;
    end

    // Single register step; the frame is idle low on the clock line
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{st: H_WAKE, div: 3'h3, sck: 1'b0, cs_n: 1'b1, o: 4'hc, oe: 4'hc,
                   cmd: 20'h0_0000, pin: sfp_pkg::PIN_RST, part: 1'b0, run: 1'b0, cnt: 4'h0,
                   sh: 8'h00, rx: 8'h00, ack: 1'b0, dat: 32'h0000_0000,
                   s1: 4'hf, s2: 4'hf};
        end else begin
            q <= d;
        end
    end

    assign link.sck     = q.sck;
    assign link.cs_n    = q.cs_n;
    assign link.host_o  = q.o;
    assign link.host_oe = q.oe;
    assign dat_o        = q.dat;
    assign ack_o        = q.ack;
endmodule : sfp_host_end

// ---- sfp_link_sva.sv ----
// Assertion checker for the serial flash pin link
`timescale 1ns/1ps
module sfp_link_sva (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic [3:0] host_oe,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe
);
    // ------------------------------------------------------------
    // Rises seen in the current frame
    // ------------------------------------------------------------
    logic [3:0] rise_q;

    // Saturates so long frames never wrap back under eight
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            rise_q <= 4'h0;
        else if (cs_n)
            rise_q <= 4'h0;
        else if ($rose(sck) && rise_q != 4'hf)
            rise_q <= rise_q + 4'h1;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    deselect_float_a: assert property (cs_n && $past(cs_n) |-> dev_oe == 4'h0)
        else $error("device drives while deselected");
    early_drive_a: assert property (!cs_n && rise_q < 4'h8 |-> dev_oe == 4'h0)
        else $error("device drives before its answer phase");
    no_clash_a: assert property ((dev_oe & host_oe) == 4'h0)
        else $error("both ends drive one line");
    fall_launch_a: assert property (dev_oe != 4'h0 && $changed(dev_o) |-> $fell(sck))
        else $error("device data changed off a falling edge");
    sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("clock high phase not four cycles");
    sck_low_a: assert property ($fell(sck) && !cs_n |-> !sck [*4])
        else $error("clock low phase too short");
    cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select high gap too short");
    select_idle_a: assert property ($fell(cs_n) |-> !sck)
        else $error("select fell with clock high");

    cover property (dev_oe == 4'h2);
    cover property (dev_oe == 4'h3);
    cover property (dev_oe == 4'hf);
endmodule : sfp_link_sva

// ---- tb_top.sv ----
// Self-checking bench joining host end and flash end
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [7:0]  tx      = 8'h00;
    logic [31:0] dat     = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic [7:0]  st_w;
    logic [7:0]  rx_b;
    logic [7:0]  v;
    logic        ack_o;
    logic        rxt;
    logic        fsel;
    logic        act;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          seed       = 89;
    int          cycles     = 0;
    int          st_m       = 0;
    int          pin_m      = 3;

    sfp_link_if link ();
    sfp_host_end i_sfp_host_end (.link(link.host), .clk_sys(clk_sys), .rst(rst), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o));
    sfp_flash_end i_sfp_flash_end (.link(link.dev), .rst(rst), .tx_byte(tx),
        .status_word(st_w), .func_select(fsel), .rx_byte(rx_b), .rx_toggle(rxt),
        .dev_active(act));
    sfp_link_sva i_sfp_link_sva (.clk_sys(clk_sys), .rst(rst), .sck(link.sck),
        .cs_n(link.cs_n), .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe));

    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial forever #2 clk_sys = ~clk_sys;

    // Whole run needs about three thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Classic cycle; held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk_sys); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic idle();
        do wb(1'b0, sfp_pkg::ADR_STAT, 32'h0); while (rd[0] !== 1'b0);
    endtask : idle

    task automatic cmd(input logic [1:0] ln, input logic [1:0] k, input logic [7:0] a,
                       input logic [7:0] op);
        idle();
        wb(1'b1, sfp_pkg::ADR_CMD, {12'h000, ln, k, a, op});
        idle();
    endtask : cmd

    task automatic pin(input int p);
        pin_m = p;
        wb(1'b1, sfp_pkg::ADR_PIN, 32'(p));
    endtask : pin

    // Model: lock set, quad clear and protect low refuse the write
    task automatic ws(input logic [7:0] d);
        cmd(sfp_pkg::LANE1, sfp_pkg::KIND_WR, d, sfp_pkg::OP_WRITE_STATUS);
        if (!(st_m[7] && !st_m[6] && pin_m[0] == 0))
            st_m = d & 8'hfc;
        check("status", st_w, st_m[7:0]);
    endtask : ws

    task automatic rdc(input logic [1:0] ln, input logic [7:0] op, input logic [7:0] e);
        cmd(ln, sfp_pkg::KIND_RD, 8'h00, op);
        check("read byte", rd[15:8], e);
    endtask : rdc

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, sfp_pkg::ADR_PIN, 32'h0);
        check("pin reset", rd, 32'h3);
        wb(1'b0, 8'h0c, 32'h0);
        check("unmapped", rd, 32'h0);
        ws(8'($random(seed)) & 8'h3c);
        pin(2);
        ws(8'h14);
        pin(3);
        ws(8'h80);
        pin(2);
        ws(8'h3c);
        pin(3);
        ws(8'h88);
        rdc(sfp_pkg::LANE1, sfp_pkg::OP_READ_STATUS, st_m[7:0]);
        check("standby", act, 1'b0);
        $display("protect test done");
        cmd(sfp_pkg::LANE1, sfp_pkg::KIND_WR, 8'h80, sfp_pkg::OP_WRITE_FUNC);
        check("fsel", fsel, 1'b1);
        rdc(sfp_pkg::LANE1, sfp_pkg::OP_READ_FUNC, 8'h80);
        ws(8'h24);
        pin(1);
        repeat (8) @(posedge clk_sys);
        pin(3);
        check("kept", st_w, st_m[7:0]);
        rdc(sfp_pkg::LANE1, sfp_pkg::OP_READ_STATUS, st_m[7:0]);
        cmd(sfp_pkg::LANE1, sfp_pkg::KIND_WR, 8'h00, sfp_pkg::OP_WRITE_FUNC);
        $display("restart test done");
        tx <= 8'($random(seed));
        idle();
        wb(1'b1, sfp_pkg::ADR_CMD, {14'h0000, sfp_pkg::KIND_RD, 8'h00, sfp_pkg::OP_READ_DATA});
        repeat (40) @(posedge clk_sys);
        pin(1);
        repeat (100) @(posedge clk_sys);
        wb(1'b0, sfp_pkg::ADR_STAT, 32'h0);
        check("paused", rd[0], 1'b1);
        check("active", act, 1'b1);
        pin(3);
        idle();
        check("resumed", rd[15:8], tx);
        v = 8'($random(seed));
        cmd(sfp_pkg::LANE1, sfp_pkg::KIND_WR, v, sfp_pkg::OP_WRITE_DATA);
        check("rx byte", rx_b, v);
        check("rx toggle", rxt, 1'b1);
        rdc(sfp_pkg::LANE2, sfp_pkg::OP_READ_DUAL, tx);
        rdc(sfp_pkg::LANE4, sfp_pkg::OP_READ_QUAD, 8'hff);
        ws(8'h40);
        rdc(sfp_pkg::LANE4, sfp_pkg::OP_READ_QUAD, tx);
        ws(8'hc0);
        pin(2);
        ws(8'hd8);
        $display("lane test done");
        conclude();
    end
endmodule : tb_top
